// >>> inc/lane_xbar_consts.vh
/*
  Register offsets, field positions and reset values for the serial lane
  crossbar control block.
  Assumes an include path that reaches inc/ and is shared by rtl/ and tb/.
*/
`ifndef LANE_XBAR_CONSTS_VH
`define LANE_XBAR_CONSTS_VH

// register address width and data width
`define XBAR_ADDR_W 15
`define XBAR_DATA_W 8

// register offsets
`define OFS_LANE_POWER_DOWN_CONTROL 15'h05b0
`define OFS_PHYSICAL_LANE0_MAPPING 15'h05b2
`define OFS_PHYSICAL_LANE1_MAPPING 15'h05b3
`define OFS_PHYSICAL_LANE2_MAPPING 15'h05b5
`define OFS_PHYSICAL_LANE3_MAPPING 15'h05b6
`define OFS_LANE_POLARITY_INVERT 15'h05bf

// reset values
`define RST_LANE_POWER_DOWN_CONTROL 8'h00
`define RST_PHYSICAL_LANE0_MAPPING 3'h0
`define RST_PHYSICAL_LANE1_MAPPING 3'h1
`define RST_PHYSICAL_LANE2_MAPPING 3'h2
`define RST_PHYSICAL_LANE3_MAPPING 3'h3
`define RST_LANE_POLARITY_INVERT 8'h00

// field layout
`define MAP_FIELD_MSB 2
`define MAP_FIELD_W 3
`define POWER_DOWN_BITS_MASK 8'h55
`define UNMAPPED_READ_VALUE 8'h00

// logical lane codes of a mapping field
`define MAP_CODE_LOGICAL_0 3'h0
`define MAP_CODE_LOGICAL_1 3'h1
`define MAP_CODE_LOGICAL_2 3'h2
`define MAP_CODE_LOGICAL_3 3'h3

`endif

// >>> rtl/serial_lane_crossbar_control.v
/*
  Control registers and datapath for four serial output lanes: forced
  power-down, physical-to-logical lane crossbar and per-lane polarity invert.
  Assumes a simple synchronous register port (one access per strobe) driven
  by the device's control interface logic, and logical lane words presented
  synchronously to CLK_SYS by the link framer upstream.
*/
`timescale 1ns/1ps
`default_nettype none
`include "lane_xbar_consts.vh"

// Summary of operation
// R1: bits 6 and 4 force physical lanes 3 and 2 into power-down; reset zero.
// R2: bits 2 and 0 force lanes 1 and 0 down; odd bits reserved read-only.
// R3: lane 0 selector, three bits, codes 0..3 pick logical lane; resets to 0.
// R4: lane 1 selector picks its logical lane, same code map; resets to 1.
// R5: lane 2 selector picks its logical lane; resets to 2.
// R6: lane 3 selector picks its logical lane; resets to 3, identity by default.
// R7: invert bits 6,4,2,0 invert lanes 3,2,1,0 data; zero passes; reset zero.

module serial_lane_crossbar_control #(
  parameter LANE_W = 8
) (
  // clock and reset
  input wire CLK_SYS,
  input wire RESET,
  // register port
  input wire [`XBAR_ADDR_W-1:0] REG_ADDR,
  input wire REG_WR,
  input wire [`XBAR_DATA_W-1:0] REG_WDATA,
  input wire REG_RD,
  output reg [`XBAR_DATA_W-1:0] REG_RDATA,
  output reg REG_RVALID,
  // logical lanes from the framer
  input wire [LANE_W-1:0] LOGICAL_LANE_0,
  input wire [LANE_W-1:0] LOGICAL_LANE_1,
  input wire [LANE_W-1:0] LOGICAL_LANE_2,
  input wire [LANE_W-1:0] LOGICAL_LANE_3,
  // physical lanes to the serializers
  output reg [LANE_W-1:0] SERIAL_OUTPUT_LANE_0,
  output reg [LANE_W-1:0] SERIAL_OUTPUT_LANE_1,
  output reg [LANE_W-1:0] SERIAL_OUTPUT_LANE_2,
  output reg [LANE_W-1:0] SERIAL_OUTPUT_LANE_3,
  output reg [3:0] LANE_POWER_DOWN
);

  ////////////////////////////////////////////////////////////////////////////
  // register state

  reg [`XBAR_DATA_W-1:0] power_down_ctl;
  reg [`MAP_FIELD_W-1:0] lane0_map;
  reg [`MAP_FIELD_W-1:0] lane1_map;
  reg [`MAP_FIELD_W-1:0] lane2_map;
  reg [`MAP_FIELD_W-1:0] lane3_map;
  reg [`XBAR_DATA_W-1:0] invert_ctl;

  wire [4*LANE_W-1:0] logical_bus;
  assign logical_bus = {LOGICAL_LANE_3, LOGICAL_LANE_2, LOGICAL_LANE_1, LOGICAL_LANE_0};

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // crossbar pick; codes above 3 have no logical lane, so send idle zeros
  // rather than alias onto a lane and duplicate its data
  function [LANE_W-1:0] pick_lane;
    input [`MAP_FIELD_W-1:0] code;
    input [4*LANE_W-1:0] bus;
    begin
      case (code)
        `MAP_CODE_LOGICAL_0: pick_lane = bus[LANE_W-1:0];
        `MAP_CODE_LOGICAL_1: pick_lane = bus[2*LANE_W-1:LANE_W];
        `MAP_CODE_LOGICAL_2: pick_lane = bus[3*LANE_W-1:2*LANE_W];
        `MAP_CODE_LOGICAL_3: pick_lane = bus[4*LANE_W-1:3*LANE_W];
        default: pick_lane = {LANE_W{1'b0}};
      endcase
    end
  endfunction

  // polarity and power-down applied after the crossbar
  function [LANE_W-1:0] lane_out;
    input [LANE_W-1:0] data;
    input invert;
    input down;
    begin
      if (down) begin
        lane_out = {LANE_W{1'b0}};
      end else if (invert) begin
        lane_out = ~data;
      end else begin
        lane_out = data;
      end
    end
  endfunction

  // mapping field read back with the reserved upper bits as zero
  function [`XBAR_DATA_W-1:0] map_read;
    input [`MAP_FIELD_W-1:0] field;
    begin
      map_read = {{(`XBAR_DATA_W-`MAP_FIELD_W){1'b0}}, field};
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // register writes

  wire wr_power_down;
  wire wr_lane0;
  wire wr_lane1;
  wire wr_lane2;
  wire wr_lane3;
  wire wr_invert;
  assign wr_power_down = REG_WR && (REG_ADDR == `OFS_LANE_POWER_DOWN_CONTROL);
  assign wr_lane0 = REG_WR && (REG_ADDR == `OFS_PHYSICAL_LANE0_MAPPING);
  assign wr_lane1 = REG_WR && (REG_ADDR == `OFS_PHYSICAL_LANE1_MAPPING);
  assign wr_lane2 = REG_WR && (REG_ADDR == `OFS_PHYSICAL_LANE2_MAPPING);
  assign wr_lane3 = REG_WR && (REG_ADDR == `OFS_PHYSICAL_LANE3_MAPPING);
  assign wr_invert = REG_WR && (REG_ADDR == `OFS_LANE_POLARITY_INVERT);

  always @(posedge CLK_SYS) begin
    if (RESET) begin
      power_down_ctl <= `RST_LANE_POWER_DOWN_CONTROL; // R1 R2
      lane0_map <= `RST_PHYSICAL_LANE0_MAPPING; // R3
      lane1_map <= `RST_PHYSICAL_LANE1_MAPPING; // R4
      lane2_map <= `RST_PHYSICAL_LANE2_MAPPING; // R5
      lane3_map <= `RST_PHYSICAL_LANE3_MAPPING; // R6
      invert_ctl <= `RST_LANE_POLARITY_INVERT; // R7
    end else begin
      if (wr_power_down) begin
        // odd bits are read-only zero, so they never store
        power_down_ctl <= REG_WDATA & `POWER_DOWN_BITS_MASK; // R1 R2
      end
      if (wr_lane0) begin
        lane0_map <= REG_WDATA[`MAP_FIELD_MSB:0]; // R3
      end
      if (wr_lane1) begin
        lane1_map <= REG_WDATA[`MAP_FIELD_MSB:0]; // R4
      end
      if (wr_lane2) begin
        lane2_map <= REG_WDATA[`MAP_FIELD_MSB:0]; // R5
      end
      if (wr_lane3) begin
        lane3_map <= REG_WDATA[`MAP_FIELD_MSB:0]; // R6
      end
      if (wr_invert) begin
        // all eight bits keep what was written, reserved ones included
        invert_ctl <= REG_WDATA; // R7
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register reads

  reg [`XBAR_DATA_W-1:0] next_rdata;

  always @* begin
    case (REG_ADDR)
      `OFS_LANE_POWER_DOWN_CONTROL: next_rdata = power_down_ctl;
      `OFS_PHYSICAL_LANE0_MAPPING: next_rdata = map_read(lane0_map);
      `OFS_PHYSICAL_LANE1_MAPPING: next_rdata = map_read(lane1_map);
      `OFS_PHYSICAL_LANE2_MAPPING: next_rdata = map_read(lane2_map);
      `OFS_PHYSICAL_LANE3_MAPPING: next_rdata = map_read(lane3_map);
      `OFS_LANE_POLARITY_INVERT: next_rdata = invert_ctl;
      default: next_rdata = `UNMAPPED_READ_VALUE;
    endcase
  end

  // read data holds until the next read so a slow master can sample late
  always @(posedge CLK_SYS) begin
    if (RESET) begin
      REG_RDATA <= 8'h00;
      REG_RVALID <= 1'b0;
    end else begin
      REG_RVALID <= REG_RD;
      if (REG_RD) begin
        REG_RDATA <= next_rdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // lane datapath

  reg [LANE_W-1:0] next_lane0;
  reg [LANE_W-1:0] next_lane1;
  reg [LANE_W-1:0] next_lane2;
  reg [LANE_W-1:0] next_lane3;

  always @* begin
    next_lane0 = lane_out(pick_lane(lane0_map, logical_bus), invert_ctl[0],
      power_down_ctl[0]); // R2 R3 R7
    next_lane1 = lane_out(pick_lane(lane1_map, logical_bus), invert_ctl[2],
      power_down_ctl[2]); // R2 R4 R7
    next_lane2 = lane_out(pick_lane(lane2_map, logical_bus), invert_ctl[4],
      power_down_ctl[4]); // R1 R5 R7
    next_lane3 = lane_out(pick_lane(lane3_map, logical_bus), invert_ctl[6],
      power_down_ctl[6]); // R1 R6 R7
  end

  // one register stage between settings and pins; a register write takes
  // effect on the lanes one cycle after it is taken
  always @(posedge CLK_SYS) begin
    if (RESET) begin
      SERIAL_OUTPUT_LANE_0 <= {LANE_W{1'b0}};
      SERIAL_OUTPUT_LANE_1 <= {LANE_W{1'b0}};
      SERIAL_OUTPUT_LANE_2 <= {LANE_W{1'b0}};
      SERIAL_OUTPUT_LANE_3 <= {LANE_W{1'b0}};
      LANE_POWER_DOWN <= 4'h0;
    end else begin
      SERIAL_OUTPUT_LANE_0 <= next_lane0;
      SERIAL_OUTPUT_LANE_1 <= next_lane1;
      SERIAL_OUTPUT_LANE_2 <= next_lane2;
      SERIAL_OUTPUT_LANE_3 <= next_lane3;
      LANE_POWER_DOWN <= {power_down_ctl[6], power_down_ctl[4],
        power_down_ctl[2], power_down_ctl[0]}; // R1 R2
    end
  end

endmodule

`default_nettype wire

// >>> tb/lane_rx_model.sv
/* Receiver-side sink for the four physical lanes.
   Assumes it shares the block's clock. */
`timescale 1ns/1ps
`default_nettype none
module lane_rx_model #(parameter LANE_W = 8) (
  input wire logic clk,
  input wire logic [4*LANE_W-1:0] lanes,
  input wire logic [3:0] down,
  output logic [4*LANE_W-1:0] rx
);
  // a downed lane delivers no symbols, so its slot is held
  always @(posedge clk)
    for (int i = 0; i < 4; i++)
      if (!down[i]) rx[i*LANE_W +: LANE_W] <= lanes[i*LANE_W +: LANE_W];
endmodule
`default_nettype wire

// >>> tb/lane_xbar_props.sv
/* Port checker for the lane crossbar block.
   Assumes the bind below and the shared constants header. */
`timescale 1ns/1ps
`default_nettype none
`include "lane_xbar_consts.vh"
module lane_xbar_props #(parameter LANE_W = 8) (
  // clock, reset, register port
  input wire logic CLK_SYS, RESET, REG_WR, REG_RD, REG_RVALID,
  input wire logic [`XBAR_ADDR_W-1:0] REG_ADDR,
  input wire logic [`XBAR_DATA_W-1:0] REG_WDATA, REG_RDATA,
  // lanes
  input wire logic [LANE_W-1:0] LOGICAL_LANE_0, LOGICAL_LANE_1, LOGICAL_LANE_2,
  input wire logic [LANE_W-1:0] LOGICAL_LANE_3, SERIAL_OUTPUT_LANE_0, SERIAL_OUTPUT_LANE_1,
  input wire logic [LANE_W-1:0] SERIAL_OUTPUT_LANE_2, SERIAL_OUTPUT_LANE_3,
  input wire logic [3:0] LANE_POWER_DOWN
);
  wire logic w_pd = REG_WR && REG_ADDR == `OFS_LANE_POWER_DOWN_CONTROL;
  wire logic w_inv = REG_WR && REG_ADDR == `OFS_LANE_POLARITY_INVERT;
  logic [LANE_W-1:0] lg_q [0:3];
  logic inv0;
  // lanes as the output stage took them one edge earlier; shadow of lane 0
  // invert, only to know when a write really toggles it
  always @(posedge CLK_SYS) begin
    lg_q[0] <= LOGICAL_LANE_0;
    lg_q[1] <= LOGICAL_LANE_1;
    lg_q[2] <= LOGICAL_LANE_2;
    lg_q[3] <= LOGICAL_LANE_3;
    if (RESET) inv0 <= 1'b0;
    else if (w_inv) inv0 <= REG_WDATA[0];
  end
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (RESET);
  // register lands on the write edge, pins one edge later, seen on the second; checked on the third
  property p_pd_hi;
    w_pd |=> ##2 LANE_POWER_DOWN[3:2] == {$past(REG_WDATA[6], 3), $past(REG_WDATA[4], 3)};
  endproperty
  property p_pd_lo;
    w_pd |=> ##2 LANE_POWER_DOWN[1:0] == {$past(REG_WDATA[2], 3), $past(REG_WDATA[0], 3)};
  endproperty
  // invert bit unknown here, so either polarity is accepted
  property p_map0;
    (REG_WR && REG_ADDR == `OFS_PHYSICAL_LANE0_MAPPING && !REG_WDATA[2]) |=> ##2
      (LANE_POWER_DOWN[0] ? SERIAL_OUTPUT_LANE_0 == 0 :
      (SERIAL_OUTPUT_LANE_0 == lg_q[$past(REG_WDATA[1:0], 3)] ||
      SERIAL_OUTPUT_LANE_0 == ~lg_q[$past(REG_WDATA[1:0], 3)]));
  endproperty
  property p_map1;
    (REG_WR && REG_ADDR == `OFS_PHYSICAL_LANE1_MAPPING && !REG_WDATA[2]) |=> ##2
      (LANE_POWER_DOWN[1] ? SERIAL_OUTPUT_LANE_1 == 0 :
      (SERIAL_OUTPUT_LANE_1 == lg_q[$past(REG_WDATA[1:0], 3)] ||
      SERIAL_OUTPUT_LANE_1 == ~lg_q[$past(REG_WDATA[1:0], 3)]));
  endproperty
  property p_map2;
    (REG_WR && REG_ADDR == `OFS_PHYSICAL_LANE2_MAPPING && !REG_WDATA[2]) |=> ##2
      (LANE_POWER_DOWN[2] ? SERIAL_OUTPUT_LANE_2 == 0 :
      (SERIAL_OUTPUT_LANE_2 == lg_q[$past(REG_WDATA[1:0], 3)] ||
      SERIAL_OUTPUT_LANE_2 == ~lg_q[$past(REG_WDATA[1:0], 3)]));
  endproperty
  property p_map3;
    (REG_WR && REG_ADDR == `OFS_PHYSICAL_LANE3_MAPPING && !REG_WDATA[2]) |=> ##2
      (LANE_POWER_DOWN[3] ? SERIAL_OUTPUT_LANE_3 == 0 :
      (SERIAL_OUTPUT_LANE_3 == lg_q[$past(REG_WDATA[1:0], 3)] ||
      SERIAL_OUTPUT_LANE_3 == ~lg_q[$past(REG_WDATA[1:0], 3)]));
  endproperty
  property p_inv;
    (w_inv && REG_WDATA[0] != inv0) ##2 ($stable(LOGICAL_LANE_0) && $stable(LOGICAL_LANE_1)
      && $stable(LOGICAL_LANE_2) && $stable(LOGICAL_LANE_3))
      |=> LANE_POWER_DOWN[0] || SERIAL_OUTPUT_LANE_0 == ~$past(SERIAL_OUTPUT_LANE_0);
  endproperty
  a_pd_hi: assert property (p_pd_hi) else $error("lane 3/2 power-down wrong");
  a_pd_lo: assert property (p_pd_lo) else $error("lane 1/0 power-down wrong");
  a_map0: assert property (p_map0) else $error("lane 0 routing wrong");
  a_map1: assert property (p_map1) else $error("lane 1 routing wrong");
  a_map2: assert property (p_map2) else $error("lane 2 routing wrong");
  a_map3: assert property (p_map3) else $error("lane 3 routing wrong");
  a_inv: assert property (p_inv) else $error("lane 0 polarity not toggled");
  c_pd: cover property (LANE_POWER_DOWN == 4'hf);
  c_inv: cover property (w_inv && REG_WDATA[0]);
  c_rd: cover property (REG_RVALID);
endmodule
bind serial_lane_crossbar_control lane_xbar_props #(.LANE_W(LANE_W)) props_i (.CLK_SYS,
  .RESET, .REG_WR, .REG_RD, .REG_RVALID, .REG_ADDR, .REG_WDATA, .REG_RDATA, .LOGICAL_LANE_0,
  .LOGICAL_LANE_1, .LOGICAL_LANE_2, .LOGICAL_LANE_3, .SERIAL_OUTPUT_LANE_0,
  .SERIAL_OUTPUT_LANE_1, .SERIAL_OUTPUT_LANE_2, .SERIAL_OUTPUT_LANE_3, .LANE_POWER_DOWN);
`default_nettype wire

// >>> tb/testbench.sv
/* Self-checking bench for the lane crossbar block.
   Assumes the constants header on the include path. */
`timescale 1ns/1ps
`default_nettype none
`include "lane_xbar_consts.vh"
module testbench;
  logic CLK_SYS = 1'b0, RESET = 1'b1, REG_WR = 1'b0, REG_RD = 1'b0;
  logic [14:0] REG_ADDR = 15'h0;
  logic [7:0] REG_WDATA = 8'h0;
  logic [7:0] lg [0:3] = '{8'h11, 8'h22, 8'h44, 8'h88};
  logic [14:0] ofs [0:6] = '{15'h5b0, 15'h5b2, 15'h5b3, 15'h5b5, 15'h5b6, 15'h5bf, 15'h5b1};
  logic [7:0] rst [0:6] = '{8'h0, 8'h0, 8'h1, 8'h2, 8'h3, 8'h0, 8'h0};
  int mp [0:3] = '{3, 2, 3, 0};
  wire [7:0] REG_RDATA;
  wire REG_RVALID;
  wire [3:0] LANE_POWER_DOWN;
  wire [7:0] so [0:3];
  wire [31:0] rx;
  int fail_count = 0, total_checks = 0;
  int c;
  always #25 CLK_SYS = ~CLK_SYS;
  serial_lane_crossbar_control serial_lane_crossbar_control_i (.CLK_SYS, .RESET, .REG_ADDR,
    .REG_WR, .REG_WDATA, .REG_RD, .REG_RDATA, .REG_RVALID, .LOGICAL_LANE_0(lg[0]),
    .LOGICAL_LANE_1(lg[1]), .LOGICAL_LANE_2(lg[2]), .LOGICAL_LANE_3(lg[3]),
    .SERIAL_OUTPUT_LANE_0(so[0]), .SERIAL_OUTPUT_LANE_1(so[1]),
    .SERIAL_OUTPUT_LANE_2(so[2]), .SERIAL_OUTPUT_LANE_3(so[3]), .LANE_POWER_DOWN);
  lane_rx_model lane_rx_model_i (.clk(CLK_SYS), .lanes({so[3], so[2], so[1], so[0]}),
    .down(LANE_POWER_DOWN), .rx(rx));
  task chk(input string n, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  // strobe dropped, then one idle edge, so back-to-back calls never re-drive in one step
  task wr(input logic [14:0] a, input logic [7:0] d);
    REG_ADDR = a;
    REG_WDATA = d;
    REG_WR = 1'b1;
    @(posedge CLK_SYS) #1 REG_WR = 1'b0;
    @(posedge CLK_SYS) #1;
  endtask
  task rd(input logic [14:0] a, input logic [7:0] e);
    REG_ADDR = a;
    REG_RD = 1'b1;
    @(posedge CLK_SYS) #1 REG_RD = 1'b0;
    chk("rvalid", 8'h1, {7'h0, REG_RVALID});
    chk("rdata", e, REG_RDATA);
    @(posedge CLK_SYS) #1;
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #100000 fail_count++;
    tally_and_finish;
  end
  initial begin
    repeat (3) @(posedge CLK_SYS);
    #1 RESET = 1'b0;
    for (c = 0; c < 7; c++) rd(ofs[c], rst[c]);
    for (c = 0; c < 4; c++) chk("identity", lg[c], so[c]);
    $display("reset test done");
    for (c = 0; c < 4; c++) begin
      wr(15'h5b2, 8'hf8 | c[7:0]);
      chk("lane0", lg[c], so[0]);
      rd(15'h5b2, c[7:0]);
    end
    wr(15'h5b3, 8'h2);
    wr(15'h5b5, 8'h3);
    wr(15'h5b6, 8'h0);
    for (c = 0; c < 4; c++) chk("map", lg[mp[c]], so[c]);
    $display("map test done");
    wr(15'h5bf, 8'h55);
    for (c = 0; c < 4; c++) chk("inverted", ~lg[mp[c]], so[c]);
    wr(15'h5bf, 8'haa);
    rd(15'h5bf, 8'haa);
    for (c = 0; c < 4; c++) chk("normal", lg[mp[c]], so[c]);
    $display("invert test done");
    wr(15'h5b0, 8'hff);
    rd(15'h5b0, 8'h55);
    chk("pd", 8'h0f, {4'h0, LANE_POWER_DOWN});
    for (c = 0; c < 4; c++) chk("down", 8'h0, so[c]);
    wr(15'h5b0, 8'h50);
    chk("pd", 8'h0c, {4'h0, LANE_POWER_DOWN});
    chk("live", lg[3], so[0]);
    for (c = 0; c < 4; c++) chk("rx", lg[mp[c]], rx[c*8 +: 8]);
    wr(15'h5b2, 8'h07);
    chk("code7", 8'h0, so[0]);
    rd(15'h5b2, 8'h07);
    $display("power-down test done");
    tally_and_finish;
  end
endmodule
`default_nettype wire
